// ### design/csrb_core_special_register_bank.sv
`timescale 1ns/1ps
module csrb_core_special_register_bank (
   core_clk,
   reset_n,
   fuses,
   fr_addr,
   fr_wr_en,
   fr_wdata,
   fr_rdata,
   w_value,
   w_wr_en,
   w_wdata,
   mode_wr_en,
   mode_wdata,
   mode_rdata,
   port_wr_en,
   port_sel,
   exch_valid,
   exch_data,
   option_wr_en,
   option_wdata,
   option_rdata,
   alu_req,
   alu_result,
   watchdog_clear_op,
   sleep_op,
   wd_timeout,
   wd_tick,
   wd_div_tick,
   pc_load,
   pc_load_value,
   pc_low,
   page_select,
   port_a_pins,
   port_b_pins,
   port_c_pins,
   counter_pin,
   comparator_above,
   port_a_out,
   port_b_out,
   port_c_out,
   port_ctrl,
   comparator_enable,
   comparator_drive_pin0,
   wake_pending_flags,
   rollover_irq,
   instr_tick
);
   import csrb_pkg::*;

   input  wire logic                 core_clk;
   input  wire logic                 reset_n;
   input  wire csrb_pkg::csrb_fuse_t fuses;
   input  wire logic [4:0]           fr_addr;
   input  wire logic                 fr_wr_en;
   input  wire logic [7:0]           fr_wdata;
   output logic      [7:0]           fr_rdata;
   input  wire logic [7:0]           w_value;
   output logic                      w_wr_en;
   output logic      [7:0]           w_wdata;
   input  wire logic                 mode_wr_en;
   input  wire logic [7:0]           mode_wdata;
   output logic      [7:0]           mode_rdata;
   input  wire logic                 port_wr_en;
   input  wire logic [1:0]           port_sel;
   output logic                      exch_valid;
   output logic      [7:0]           exch_data;
   input  wire logic                 option_wr_en;
   input  wire logic [7:0]           option_wdata;
   output logic      [7:0]           option_rdata;
   input  wire csrb_pkg::csrb_alu_req_t alu_req;
   output logic      [7:0]           alu_result;
   input  wire logic                 watchdog_clear_op;
   input  wire logic                 sleep_op;
   input  wire logic                 wd_timeout;
   input  wire logic                 wd_tick;
   output logic                      wd_div_tick;
   input  wire logic                 pc_load;
   input  wire logic [7:0]           pc_load_value;
   output logic      [7:0]           pc_low;
   output logic      [2:0]           page_select;
   input  wire logic [7:0]           port_a_pins;
   input  wire logic [7:0]           port_b_pins;
   input  wire logic [7:0]           port_c_pins;
   input  wire logic                 counter_pin;
   input  wire logic                 comparator_above;
   output logic      [7:0]           port_a_out;
   output logic      [7:0]           port_b_out;
   output logic      [7:0]           port_c_out;
   output csrb_pkg::csrb_ctrl_t      port_ctrl;
   output logic                      comparator_enable;
   output logic                      comparator_drive_pin0;
   output logic      [7:0]           wake_pending_flags;
   output logic                      rollover_irq;
   output logic                      instr_tick;

   // Whole state of the bank in one record.
   typedef struct packed {
      logic [7:0]  counter;
      logic [7:0]  presc;
      logic [7:0]  pc_low;
      logic [7:0]  status;
      logic [7:0]  fsel;
      logic [7:0]  pa;
      logic [7:0]  pb;
      logic [7:0]  pc;
      logic [7:0]  mode;
      logic [7:0]  option;
      logic [7:0]  wake;
      logic [7:0]  cmp;
      csrb_ctrl_t  ctrl;
      logic [8:0]  sync1;
      logic [8:0]  sync2;
      logic [8:0]  prev;
      logic [1:0]  div;
      logic [7:0]  rdata;
      logic        w_wr;
      logic [7:0]  w_data;
      logic        exch;
      logic [7:0]  exch_data;
      logic [7:0]  alu_res;
      logic        wd_out;
      logic        roll;
   } csrb_state_t;

   csrb_state_t s_q;
   csrb_state_t s_d;

   // Low-bit mask for a power-of-two divide; used for both prescaler taps.
   function automatic logic [7:0] csrb_mask(input logic [3:0] n);
      csrb_mask = 8'(9'(1) << n) - 8'h01;
   endfunction

   // Flag results of an execution-unit request: {result, zero, nibble, carry}.
   function automatic logic [10:0] csrb_alu(input csrb_alu_req_t r, input logic c_in,
                                             input logic c_old);
      logic [4:0] lo;
      logic [8:0] full;
      logic [7:0] res;
      logic       nib;
      logic       cy;
      lo   = 5'h00;
      full = 9'h000;
      res  = r.a;
      nib  = 1'b0;
      cy   = c_old;
      unique case (r.op)
         CSRB_OP_ADD: begin
            lo   = {1'b0, r.a[3:0]} + {1'b0, r.b[3:0]} + {4'h0, c_in};
            full = {1'b0, r.a} + {1'b0, r.b} + {8'h00, c_in};
            res  = full[7:0];
            nib  = lo[4];
            cy   = full[8];
         end
         CSRB_OP_SUB: begin
            // Carry out of a + ~b + 1 is exactly "no borrow".
            lo   = {1'b0, r.a[3:0]} + {1'b0, ~r.b[3:0]} + {4'h0, c_in};
            full = {1'b0, r.a} + {1'b0, ~r.b} + {8'h00, c_in};
            res  = full[7:0];
            nib  = lo[4];
            cy   = full[8];
         end
         CSRB_OP_RR: begin
            res = {c_old, r.a[7:1]};
            cy  = r.a[0];
         end
         CSRB_OP_RL: begin
            res = {r.a[6:0], c_old};
            cy  = r.a[7];
         end
         CSRB_OP_LOGIC: res = r.b;
         CSRB_OP_NONE:  res = r.a;
         default:       res = r.a;
      endcase
      csrb_alu = {res, (res == 8'h00), nib, cy};
   endfunction

   logic [8:0]  pins_in;
   logic [8:0]  pins_now;
   logic [4:0]  eff_addr;
   logic [7:0]  cmp_view;
   logic [10:0] alu_out;
   logic        src_event;
   logic        cnt_step;

   assign pins_in = {counter_pin, port_b_pins};
   // Bypassing the flops saves two cycles of latency but trusts the pins to be clean.
   assign pins_now = fuses.input_sync_n ? pins_in : s_q.sync2;
   // Indirect access falls through the file select pointer.
   assign eff_addr = (fr_addr == CSRB_ADDR_INDIRECT) ? s_q.fsel[4:0] : fr_addr;
   assign cmp_view = {s_q.cmp[7:1], ~s_q.cmp[CSRB_CMP_DISABLE] & comparator_above};

   always_comb begin
      s_d         = s_q;
      s_d.w_wr    = 1'b0;
      s_d.exch    = 1'b0;
      s_d.wd_out  = 1'b0;
      s_d.roll    = 1'b0;
      src_event   = 1'b0;
      cnt_step    = 1'b0;
      // With the carry input fused off a subtract still needs its +1 to stay a true a - b.
      alu_out     = csrb_alu(alu_req, fuses.carry_input_fuse_n ? (alu_req.op == CSRB_OP_SUB)
                                                               : s_q.status[CSRB_ST_CARRY],
                             s_q.status[CSRB_ST_CARRY]);

      // Two-flop synchroniser; the first stage feeds only the second.
      s_d.sync1 = pins_in;
      s_d.sync2 = s_q.sync1;
      s_d.prev  = pins_now;

      // Instruction tick: every clock in fast mode, else every fourth clock.
      s_d.div = s_q.div + 2'h1;

      // Mode selector keeps its value until rewritten.
      if (mode_wr_en) begin
         s_d.mode = mode_wdata;
      end

      // Option writes; the extension fuse pins the top two bits high.
      if (option_wr_en) begin
         s_d.option = option_wdata;
      end
      if (fuses.option_extension_fuse) begin
         s_d.option[CSRB_OPT_WINDOW] = 1'b1;
         s_d.option[CSRB_OPT_IRQDIS] = 1'b1;
      end

      // Port control writes steered by the mode selector.
      if (port_wr_en && s_q.mode >= CSRB_MODE_CMP && s_q.mode <= CSRB_MODE_RESET) begin
         if (port_sel == 2'd1 && s_q.mode == CSRB_MODE_WAKE) begin
            s_d.wake      = w_value;
            s_d.exch      = 1'b1;
            s_d.exch_data = s_q.wake;
         end else if (port_sel == 2'd1 && s_q.mode == CSRB_MODE_CMP) begin
            s_d.cmp       = w_value;
            s_d.exch      = 1'b1;
            s_d.exch_data = cmp_view;
         end else if (port_sel != 2'd3 && s_q.mode[2:0] >= 3'd2) begin
            s_d.ctrl[port_sel][s_q.mode[2:0]] = w_value;
         end
      end

      // Wake edges set pending bits after any swap, so an edge is never lost.
      for (int i = 0; i < 8; i++) begin
         if (s_q.ctrl[1][2][i] ? (s_q.prev[i] & ~pins_now[i])
                               : (~s_q.prev[i] & pins_now[i])) begin
            s_d.wake[i] = 1'b1;
         end
      end

      // Counter source: instruction cycle or selected pin edge.
      if (s_q.option[CSRB_OPT_SOURCE]) begin
         src_event = s_q.option[CSRB_OPT_EDGE] ? (s_q.prev[8] & ~pins_now[8])
                                               : (~s_q.prev[8] & pins_now[8]);
      end else begin
         src_event = instr_tick;
      end

      // Prescaler belongs either to the counter or to the watchdog.
      if (!s_q.option[CSRB_OPT_ASSIGN]) begin
         if (src_event) begin
            s_d.presc = s_q.presc + 8'h01;
            cnt_step  = (s_q.presc & csrb_mask({1'b0, s_q.option[2:0]} + 4'h1)) ==
                        csrb_mask({1'b0, s_q.option[2:0]} + 4'h1);
         end
      end else begin
         cnt_step = src_event;
         if (wd_tick) begin
            s_d.presc  = s_q.presc + 8'h01;
            s_d.wd_out = (s_q.presc & csrb_mask({1'b0, s_q.option[2:0]})) ==
                         csrb_mask({1'b0, s_q.option[2:0]});
         end
      end
      if (cnt_step) begin
         s_d.counter = s_q.counter + 8'h01;
         s_d.roll    = (s_q.counter == 8'hFF) & ~s_q.option[CSRB_OPT_IRQDIS];
      end

      if (pc_load) begin
         s_d.pc_low = pc_load_value;
      end

      // File register writes.
      s_d.w_data = fr_wdata;
      if (fr_wr_en) begin
         unique case (eff_addr)
            CSRB_ADDR_COUNTER: begin
               if (s_q.option[CSRB_OPT_WINDOW]) begin
                  s_d.counter = fr_wdata;
                  s_d.presc   = 8'h00;
               end else begin
                  s_d.w_wr = 1'b1;
               end
            end
            CSRB_ADDR_PC_LOW: s_d.pc_low = fr_wdata;
            CSRB_ADDR_STATUS: begin
               s_d.status[7:5] = fr_wdata[7:5];
               s_d.status[2:0] = fr_wdata[2:0];
            end
            CSRB_ADDR_FSEL:   s_d.fsel = fr_wdata;
            CSRB_ADDR_PORT_A: s_d.pa = fr_wdata;
            CSRB_ADDR_PORT_B: s_d.pb = fr_wdata;
            CSRB_ADDR_PORT_C: s_d.pc = fr_wdata;
            default: ;
         endcase
      end

      // Flag update lands after the write, so it may overwrite written flags.
      if (alu_req.valid && alu_req.op != CSRB_OP_NONE) begin
         s_d.alu_res = alu_out[10:3];
         if (alu_req.op != CSRB_OP_RR && alu_req.op != CSRB_OP_RL) begin
            s_d.status[CSRB_ST_ZERO] = alu_out[2];
         end
         if (alu_req.op == CSRB_OP_ADD || alu_req.op == CSRB_OP_SUB) begin
            s_d.status[CSRB_ST_NIBBLE] = alu_out[1];
         end
         if (alu_req.op != CSRB_OP_LOGIC) begin
            s_d.status[CSRB_ST_CARRY] = alu_out[0];
         end
      end

      // Watchdog and sleep events; a time-out beats a same-cycle clear.
      if (watchdog_clear_op) begin
         s_d.status[CSRB_ST_WDEXP] = 1'b1;
         s_d.status[CSRB_ST_SLEEP] = 1'b1;
      end
      if (sleep_op) begin
         s_d.status[CSRB_ST_WDEXP] = 1'b1;
         s_d.status[CSRB_ST_SLEEP] = 1'b0;
      end
      if (wd_timeout) begin
         s_d.status[CSRB_ST_WDEXP] = 1'b0;
      end

      // Registered read; port data reads the pins, not the latches.
      unique case (eff_addr)
         CSRB_ADDR_INDIRECT: s_d.rdata = 8'h00;
         CSRB_ADDR_COUNTER:  s_d.rdata = s_q.option[CSRB_OPT_WINDOW] ? s_q.counter : w_value;
         CSRB_ADDR_PC_LOW:   s_d.rdata = s_q.pc_low;
         CSRB_ADDR_STATUS:   s_d.rdata = s_q.status;
         CSRB_ADDR_FSEL:     s_d.rdata = s_q.fsel;
         CSRB_ADDR_PORT_A:   s_d.rdata = port_a_pins;
         CSRB_ADDR_PORT_B:   s_d.rdata = port_b_pins;
         CSRB_ADDR_PORT_C:   s_d.rdata = port_c_pins;
         default:            s_d.rdata = 8'h00;
      endcase
   end

   // Power-up state of the whole bank.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q         <= '0;
         s_q.ctrl    <= {24{CSRB_CTRL_RESET}};
         s_q.wake    <= CSRB_CTRL_RESET;
         s_q.cmp     <= CSRB_CTRL_RESET;
         s_q.mode    <= CSRB_MODE_RESET;
         s_q.option  <= CSRB_OPTION_RESET;
         s_q.status  <= CSRB_STATUS_RESET;
         s_q.pc_low  <= CSRB_PC_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign instr_tick            = ~fuses.fast_clock_n | (s_q.div == CSRB_DIV_LAST);
   assign fr_rdata              = s_q.rdata;
   assign w_wr_en               = s_q.w_wr;
   assign w_wdata               = s_q.w_data;
   assign mode_rdata            = s_q.mode;
   assign exch_valid            = s_q.exch;
   assign exch_data             = s_q.exch_data;
   assign option_rdata          = s_q.option;
   assign alu_result            = s_q.alu_res;
   assign wd_div_tick           = s_q.wd_out;
   assign pc_low                = s_q.pc_low;
   assign page_select           = s_q.status[7:CSRB_ST_PAGE_LSB];
   assign port_a_out            = s_q.pa;
   assign port_b_out            = s_q.pb;
   assign port_c_out            = s_q.pc;
   assign port_ctrl             = s_q.ctrl;
   assign comparator_enable     = ~s_q.cmp[CSRB_CMP_DISABLE];
   assign comparator_drive_pin0 = ~s_q.cmp[CSRB_CMP_DISABLE] & ~s_q.cmp[CSRB_CMP_NODRIVE];
   assign wake_pending_flags    = s_q.wake;
   assign rollover_irq          = s_q.roll;

endmodule // csrb_core_special_register_bank

// ### design/csrb_pkg.sv
package csrb_pkg;

   // File register addresses.
   localparam logic [4:0] CSRB_ADDR_INDIRECT = 5'h00;
   localparam logic [4:0] CSRB_ADDR_COUNTER  = 5'h01;
   localparam logic [4:0] CSRB_ADDR_PC_LOW   = 5'h02;
   localparam logic [4:0] CSRB_ADDR_STATUS   = 5'h03;
   localparam logic [4:0] CSRB_ADDR_FSEL     = 5'h04;
   localparam logic [4:0] CSRB_ADDR_PORT_A   = 5'h05;
   localparam logic [4:0] CSRB_ADDR_PORT_B   = 5'h06;
   localparam logic [4:0] CSRB_ADDR_PORT_C   = 5'h07;

   // Mode selector codes.
   localparam logic [7:0] CSRB_MODE_CMP      = 8'h08;
   localparam logic [7:0] CSRB_MODE_WAKE     = 8'h09;
   localparam logic [7:0] CSRB_MODE_RESET    = 8'h0F;

   // Status bit positions.
   localparam int CSRB_ST_PAGE_LSB = 5;
   localparam int CSRB_ST_WDEXP    = 4;
   localparam int CSRB_ST_SLEEP    = 3;
   localparam int CSRB_ST_ZERO     = 2;
   localparam int CSRB_ST_NIBBLE   = 1;
   localparam int CSRB_ST_CARRY    = 0;

   // Option bit positions.
   localparam int CSRB_OPT_WINDOW  = 7;
   localparam int CSRB_OPT_IRQDIS  = 6;
   localparam int CSRB_OPT_SOURCE  = 5;
   localparam int CSRB_OPT_EDGE    = 4;
   localparam int CSRB_OPT_ASSIGN  = 3;
   localparam int CSRB_OPT_RATIO   = 0;

   // Comparator bit positions.
   localparam int CSRB_CMP_DISABLE = 7;
   localparam int CSRB_CMP_NODRIVE = 6;
   localparam int CSRB_CMP_RESULT  = 0;

   // Reset values, and the last count of the instruction divider.
   localparam logic [7:0] CSRB_CTRL_RESET   = 8'hFF;
   localparam logic [7:0] CSRB_OPTION_RESET = 8'hFF;
   localparam logic [7:0] CSRB_STATUS_RESET = 8'h18;
   localparam logic [7:0] CSRB_PC_RESET     = 8'hFF;
   localparam logic [1:0] CSRB_DIV_LAST     = 2'h3;

   typedef enum logic [2:0] {
      CSRB_OP_NONE  = 3'b000,
      CSRB_OP_ADD   = 3'b001,
      CSRB_OP_SUB   = 3'b010,
      CSRB_OP_RR    = 3'b011,
      CSRB_OP_RL    = 3'b100,
      CSRB_OP_LOGIC = 3'b101
   } csrb_alu_op_t;

   typedef logic [2:0][7:0][7:0] csrb_ctrl_t;

   // Static fuse straps, all active as printed.
   typedef struct packed {
      logic fast_clock_n;
      logic input_sync_n;
      logic option_extension_fuse;
      logic carry_input_fuse_n;
   } csrb_fuse_t;

   // Flag request from the execution unit.
   typedef struct packed {
      logic         valid;
      csrb_alu_op_t op;
      logic [7:0]   a;
      logic [7:0]   b;
   } csrb_alu_req_t;

endpackage

// ### verification/csrb_chk.sv
`timescale 1ns/1ps
module csrb_chk (
   input wire logic                    core_clk,
   input wire logic                    reset_n,
   input wire csrb_pkg::csrb_fuse_t    fuses,
   input wire logic [4:0]              fr_addr,
   input wire logic                    fr_wr_en,
   input wire logic [7:0]              fr_wdata,
   input wire logic [7:0]              fr_rdata,
   input wire logic [7:0]              w_value,
   input wire logic                    w_wr_en,
   input wire logic [7:0]              w_wdata,
   input wire logic                    mode_wr_en,
   input wire logic [7:0]              mode_rdata,
   input wire logic                    port_wr_en,
   input wire logic [1:0]              port_sel,
   input wire logic                    exch_valid,
   input wire logic [7:0]              exch_data,
   input wire logic [7:0]              option_rdata,
   input wire csrb_pkg::csrb_alu_req_t alu_req,
   input wire logic [7:0]              alu_result,
   input wire logic                    comparator_above,
   input wire logic                    comparator_enable,
   input wire logic [7:0]              wake_pending_flags,
   input wire logic                    rollover_irq,
   input wire logic                    instr_tick,
   input wire logic [2:0]              page_select
);
   import csrb_pkg::*;
   // Every check runs on the core clock and sleeps while reset is low.
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   logic swap_b;
   // A port B control write, the only request that can start an exchange.
   assign swap_b = port_wr_en && port_sel == 2'h1;
   a_swap_pulse: assert property (
      swap_b && mode_rdata[7:1] == 7'h04 |=> exch_valid)
      else $error("Exchange pulse missing after swap.");
   a_no_exch: assert property (
      !swap_b |=> !exch_valid) else $error("Exchange pulse without a port B write.");
   a_wake_old: assert property (
      swap_b && mode_rdata == CSRB_MODE_WAKE |=> exch_data == $past(wake_pending_flags))
      else $error("Wake swap did not return the old flags.");
   a_cmp_result: assert property (
      swap_b && mode_rdata == CSRB_MODE_CMP
      |=> exch_data[CSRB_CMP_RESULT] == $past(comparator_above && comparator_enable))
      else $error("Comparator result bit wrong on swap.");
   a_opt_force: assert property (
      fuses.option_extension_fuse && $past(fuses.option_extension_fuse)
      |-> option_rdata[7:6] == 2'b11) else $error("Option top bits not forced.");
   a_w_write: assert property (
      fr_wr_en && fr_addr == CSRB_ADDR_COUNTER && !option_rdata[CSRB_OPT_WINDOW]
      |=> w_wr_en && w_wdata == $past(fr_wdata)) else $error("Window write missed W.");
   a_w_read: assert property (
      fr_addr == CSRB_ADDR_COUNTER && !option_rdata[CSRB_OPT_WINDOW]
      |=> fr_rdata == $past(w_value)) else $error("Window read did not return W.");
   a_page_write: assert property (
      fr_wr_en && fr_addr == CSRB_ADDR_STATUS && !alu_req.valid
      |=> page_select == $past(fr_wdata[7:5])) else $error("Page select not written.");
   a_logic_res: assert property (
      alu_req.valid && alu_req.op == CSRB_OP_LOGIC |=> alu_result == $past(alu_req.b))
      else $error("Logic result wrong.");
   a_irq_gate: assert property (
      rollover_irq |-> !$past(option_rdata[CSRB_OPT_IRQDIS]))
      else $error("Rollover interrupt while disabled.");
   a_fast_tick: assert property (
      !fuses.fast_clock_n |-> instr_tick) else $error("Fast clock tick missing.");
   a_mode_hold: assert property (
      !mode_wr_en && !$past(mode_wr_en) |=> $stable(mode_rdata))
      else $error("Mode selector changed unwritten.");
   c_swap: cover property (swap_b ##1 exch_valid);
   c_wwr: cover property (w_wr_en);
   c_irq: cover property (rollover_irq);
endmodule // csrb_chk

bind csrb_core_special_register_bank csrb_chk csrb_chk_u (
   .core_clk, .reset_n, .fuses, .fr_addr, .fr_wr_en, .fr_wdata, .fr_rdata,
   .w_value, .w_wr_en, .w_wdata, .mode_wr_en, .mode_rdata, .port_wr_en,
   .port_sel, .exch_valid, .exch_data, .option_rdata, .alu_req, .alu_result,
   .comparator_above, .comparator_enable, .wake_pending_flags, .rollover_irq,
   .instr_tick, .page_select);

// ### verification/csrb_cpu_model.sv
`timescale 1ns/1ps
module csrb_cpu_model (
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   input  wire logic       w_wr_en,
   input  wire logic [7:0] w_wdata,
   input  wire logic       exch_valid,
   input  wire logic [7:0] exch_data,
   output logic      [7:0] w_value
);
   // Working register; a swap wins because it is the later instruction result.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         w_value <= 8'h00;
      end else if (exch_valid) begin
         w_value <= exch_data;
      end else if (w_wr_en) begin
         w_value <= w_wdata;
      end
   end
endmodule // csrb_cpu_model

// ### verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import csrb_pkg::*;
   logic          core_clk, reset_n, fr_wr_en, mode_wr_en, port_wr_en, option_wr_en;
   logic          w_wr_en, exch_valid, wd_tick, wd_div_tick, comparator_above;
   logic          comparator_enable, comparator_drive_pin0, rollover_irq, instr_tick;
   logic [4:0]    fr_addr;
   logic [7:0]    fr_wdata, fr_rdata, w_value, w_wdata, mode_wdata, mode_rdata;
   logic [7:0]    exch_data, option_wdata, option_rdata, alu_result, pc_low;
   logic [7:0]    port_b_pins, port_a_out, port_b_out, port_c_out, wake_pending_flags;
   logic [1:0]    port_sel;
   logic [2:0]    ev, page_select;
   csrb_fuse_t    fuses;
   csrb_alu_req_t alu_req;
   csrb_ctrl_t    port_ctrl;
   int            n_mismatch, checks, i;

   csrb_core_special_register_bank dut_u (
      .core_clk(core_clk), .reset_n(reset_n), .fuses(fuses), .fr_addr(fr_addr),
      .fr_wr_en(fr_wr_en), .fr_wdata(fr_wdata), .fr_rdata(fr_rdata), .w_value(w_value),
      .w_wr_en(w_wr_en), .w_wdata(w_wdata), .mode_wr_en(mode_wr_en),
      .mode_wdata(mode_wdata), .mode_rdata(mode_rdata), .port_wr_en(port_wr_en),
      .port_sel(port_sel), .exch_valid(exch_valid), .exch_data(exch_data),
      .option_wr_en(option_wr_en), .option_wdata(option_wdata),
      .option_rdata(option_rdata), .alu_req(alu_req), .alu_result(alu_result),
      .watchdog_clear_op(ev[0]), .sleep_op(ev[1]), .wd_timeout(ev[2]),
      .wd_tick(wd_tick), .wd_div_tick(wd_div_tick), .pc_load(1'b0),
      .pc_load_value(8'h00), .pc_low(pc_low), .page_select(page_select),
      .port_a_pins(8'h00), .port_b_pins(port_b_pins), .port_c_pins(8'h00),
      .counter_pin(1'b0), .comparator_above(comparator_above),
      .port_a_out(port_a_out), .port_b_out(port_b_out), .port_c_out(port_c_out),
      .port_ctrl(port_ctrl), .comparator_enable(comparator_enable),
      .comparator_drive_pin0(comparator_drive_pin0),
      .wake_pending_flags(wake_pending_flags), .rollover_irq(rollover_irq),
      .instr_tick(instr_tick));

   csrb_cpu_model cpu_u (
      .core_clk(core_clk), .reset_n(reset_n), .w_wr_en(w_wr_en), .w_wdata(w_wdata),
      .exch_valid(exch_valid), .exch_data(exch_data), .w_value(w_value));

   // Free running core clock.
   always #2 core_clk = ~core_clk;

   task chk(input string n, input logic [7:0] e, input logic [7:0] s);
      checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask

   // A spare cycle closes each write so the working register settles first.
   task wr(input logic [4:0] a, input logic [7:0] d);
      @(negedge core_clk);
      fr_addr = a;
      fr_wdata = d;
      fr_wr_en = 1'b1;
      @(negedge core_clk);
      fr_wr_en = 1'b0;
      @(negedge core_clk);
   endtask

   task rd(input logic [4:0] a, input logic [7:0] e);
      @(negedge core_clk);
      fr_addr = a;
      @(posedge core_clk);
      #1 chk("fr_rdata", e, fr_rdata);
   endtask

   task md(input logic [7:0] m);
      @(negedge core_clk);
      mode_wdata = m;
      mode_wr_en = 1'b1;
      @(negedge core_clk);
      mode_wr_en = 1'b0;
   endtask

   task pwr(input logic [1:0] sel, input logic [7:0] e);
      @(negedge core_clk);
      port_sel = sel;
      port_wr_en = 1'b1;
      @(negedge core_clk);
      port_wr_en = 1'b0;
      if (sel == 2'h1) chk("exch_data", e, exch_data);
      @(negedge core_clk);
   endtask

   task alu(input csrb_alu_op_t op, input logic [7:0] a, input logic [7:0] b,
            input logic [7:0] e);
      @(negedge core_clk);
      alu_req = '{1'b1, op, a, b};
      @(negedge core_clk);
      alu_req.valid = 1'b0;
      chk("alu_result", e, alu_result);
   endtask

   task evt(input logic [2:0] v);
      @(negedge core_clk);
      ev = v;
      @(negedge core_clk);
      ev = 3'h0;
   endtask

   task end_of_test;
      $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Main sequence; pins start high so the flop reset reads as a rising edge only.
   initial begin
      {core_clk, reset_n, fr_wr_en, mode_wr_en, port_wr_en, option_wr_en} = 6'h00;
      {fr_addr, fr_wdata, mode_wdata, option_wdata, port_sel, ev} = 34'h0;
      {wd_tick, comparator_above, n_mismatch, checks} = '0;
      port_b_pins = 8'hFF;
      fuses = 4'h4;
      alu_req = '0;
      repeat (8) @(negedge core_clk);
      reset_n = 1'b1;
      chk("option", 8'hFF, option_rdata);
      chk("mode", CSRB_MODE_RESET, mode_rdata);
      chk("ctrl", 8'hFF, port_ctrl[0][7]);
      chk("cmp_en", 8'h00, 8'(comparator_enable));
      chk("tick", 8'h01, 8'(instr_tick));
      rd(CSRB_ADDR_STATUS, CSRB_STATUS_RESET);
      rd(CSRB_ADDR_PC_LOW, 8'hFF);
      wr(CSRB_ADDR_PC_LOW, 8'h42);
      chk("pc_low", 8'h42, pc_low);
      @(negedge core_clk);
      option_wdata = 8'h08;
      option_wr_en = 1'b1;
      @(negedge core_clk);
      option_wr_en = 1'b0;
      chk("option", 8'h08, option_rdata);
      wr(CSRB_ADDR_COUNTER, 8'h00);
      rd(CSRB_ADDR_COUNTER, 8'h00);
      md(8'h0E);
      pwr(2'h2, 8'h00);
      chk("ctrl_c6", 8'h00, port_ctrl[2][6]);
      chk("ctrl_c7", 8'hFF, port_ctrl[2][7]);
      md(CSRB_MODE_WAKE);
      pwr(2'h1, 8'hFF);
      chk("wake", 8'h00, wake_pending_flags);
      port_b_pins = 8'hF7;
      repeat (3) @(negedge core_clk);
      chk("wake", 8'h08, wake_pending_flags);
      wr(CSRB_ADDR_FSEL, 8'h06);
      rd(CSRB_ADDR_INDIRECT, 8'hF7);
      rd(CSRB_ADDR_PORT_B, 8'hF7);
      wr(CSRB_ADDR_INDIRECT, 8'hA5);
      chk("pb_out", 8'hA5, port_b_out);
      wr(CSRB_ADDR_PORT_A, 8'h3C);
      chk("pa_out", 8'h3C, port_a_out);
      // Synchronised pins see the new falling edge two cycles later than bypassed ones.
      fuses = 4'h0;
      port_b_pins = 8'hF3;
      repeat (2) @(negedge core_clk);
      chk("wake_sync", 8'h08, wake_pending_flags);
      @(negedge core_clk);
      chk("wake_sync", 8'h0C, wake_pending_flags);
      wr(CSRB_ADDR_COUNTER, 8'h00);
      md(CSRB_MODE_CMP);
      pwr(2'h1, 8'hFE);
      chk("cmp_en", 8'h01, 8'(comparator_enable));
      chk("cmp_drv", 8'h01, 8'(comparator_drive_pin0));
      comparator_above = 1'b1;
      pwr(2'h1, 8'h01);
      alu(CSRB_OP_ADD, 8'h0F, 8'h01, 8'h10);
      rd(CSRB_ADDR_STATUS, 8'h1A);
      alu(CSRB_OP_ADD, 8'hFF, 8'h01, 8'h00);
      rd(CSRB_ADDR_STATUS, 8'h1F);
      alu(CSRB_OP_LOGIC, 8'h00, 8'h5A, 8'h5A);
      wr(CSRB_ADDR_STATUS, 8'h00);
      rd(CSRB_ADDR_STATUS, 8'h18);
      wr(CSRB_ADDR_STATUS, 8'hE0);
      chk("page", 8'h07, 8'(page_select));
      evt(3'h2);
      rd(CSRB_ADDR_STATUS, 8'hF0);
      evt(3'h4);
      rd(CSRB_ADDR_STATUS, 8'hE0);
      evt(3'h1);
      rd(CSRB_ADDR_STATUS, 8'hF8);
      alu(CSRB_OP_SUB, 8'h05, 8'h03, 8'h01);
      alu(CSRB_OP_RR, 8'h80, 8'h00, 8'hC0);
      alu(CSRB_OP_RL, 8'h81, 8'h00, 8'h02);
      rd(CSRB_ADDR_STATUS, 8'hFB);
      // Carry input fused off: a plain subtract of equal values gives zero, no borrow.
      fuses = 4'h5;
      alu(CSRB_OP_SUB, 8'h05, 8'h05, 8'h00);
      rd(CSRB_ADDR_STATUS, 8'hFF);
      for (i = 0; i < 600 && rollover_irq !== 1'b1; i++) @(negedge core_clk);
      chk("irq", 8'h01, 8'(rollover_irq));
      wd_tick = 1'b1;
      @(negedge core_clk);
      chk("wd_div", 8'h01, 8'(wd_div_tick));
      fuses = 4'h6;
      repeat (2) @(negedge core_clk);
      chk("option", 8'hC8, option_rdata);
      // Window now on the counter, which steps once per clock with the prescaler elsewhere.
      wr(CSRB_ADDR_COUNTER, 8'h80);
      rd(CSRB_ADDR_COUNTER, 8'h82);
      end_of_test();
   end

   // The sequence needs under 300 cycles; this bound is over thirty times that.
   initial begin
      #40000;
      n_mismatch++;
      end_of_test();
   end
endmodule // tb_top
